// file: core/pcs_top.sv
`timescale 1ns/1ps
`include "pcs_cfg.svh"
// How it works
// - stage counter adds one per off-to-on change of its count input
// - stage done bit and value hold until the explicit clear
// - clear drops the status bit and zeroes the current value
// - current value read at word counter number plus base 1000
// - up/down value is a double word over two consecutive slots
// - up/down counts up on up edges, down on down edges, each only while the other count input is off
// - up/down held at zero while its reset input is on
// - up/down value stays within 0 to 99999999; the preset words are not range-limited
// - up/down done bit on while value is at or above preset
// - up/down preset from a constant or a word-memory double word
// - each off-to-on change of the shift clock input moves the chain and loads data at start
// - shift reset clears all relays to zero
// - start below end shifts upward, start above end downward
// - stage counter runs past preset to 9999 and holds there
module pcs_top
    import pcs_pkg::*;
#(
    parameter int STAGE_NUM = 7,
    parameter int UDC_NUM = 5,
    parameter int NREL = 64
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire pcs_bus_req_t bus,
    output logic [15:0] rdata_reg,
    // ladder program side
    input wire logic scan_pulse,
    input wire pcs_stage_in_t stage_in,
    input wire pcs_udc_in_t udc_in,
    input wire pcs_shift_in_t shift_in,
    // status and values
    output logic stage_done_reg,
    output logic udc_done_reg,
    output logic [15:0] stage_value,
    output logic [31:0] udc_value,
    output logic [NREL-1:0] relay_bits
);

    localparam int IW = $clog2(NREL);
    localparam int NWORDS = NREL / 16;
    localparam logic [15:0] STAGE_ADDR = `PCS_CUR_BASE + 16'(STAGE_NUM);
    localparam logic [15:0] UDC_LO_ADDR = `PCS_CUR_BASE + 16'(UDC_NUM);
    localparam logic [15:0] UDC_HI_ADDR = `PCS_CUR_BASE + 16'(UDC_NUM + 1);
    localparam logic [15:0] RELAY_END = `PCS_RELAY_BASE + 16'(NWORDS);

    // ==========================================================
    // software registers
    logic [15:0] ctrl_reg;
    logic [15:0] stage_pre_reg;
    logic [15:0] udc_k_lo_reg;
    logic [15:0] udc_k_hi_reg;
    logic [15:0] udc_v_lo_reg;
    logic [15:0] udc_v_hi_reg;
    logic [15:0] shift_cfg_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_reg <= `PCS_CTRL_RST;
            stage_pre_reg <= `PCS_STAGE_PRE_RST;
            udc_k_lo_reg <= `PCS_UDC_PRE_RST;
            udc_k_hi_reg <= `PCS_UDC_PRE_RST;
            udc_v_lo_reg <= `PCS_UDC_PRE_RST;
            udc_v_hi_reg <= `PCS_UDC_PRE_RST;
            shift_cfg_reg <= `PCS_SHIFT_CFG_RST;
        end else if (bus.wr) begin
            if (bus.addr == `PCS_ADDR_CTRL) begin
                ctrl_reg <= bus.wdata;
            end else if (bus.addr == `PCS_ADDR_STAGE_PRE) begin
                stage_pre_reg <= bus.wdata;
            end else if (bus.addr == `PCS_ADDR_UDC_K_LO) begin
                udc_k_lo_reg <= bus.wdata;
            end else if (bus.addr == `PCS_ADDR_UDC_K_HI) begin
                udc_k_hi_reg <= bus.wdata;
            end else if (bus.addr == `PCS_ADDR_UDC_V_LO) begin
                udc_v_lo_reg <= bus.wdata;
            end else if (bus.addr == `PCS_ADDR_UDC_V_HI) begin
                udc_v_hi_reg <= bus.wdata;
            end else if (bus.addr == `PCS_ADDR_SHIFT_CFG) begin
                shift_cfg_reg <= bus.wdata;
            end
        end
    end

    // ==========================================================
    // scan edge detection
    logic stage_prev_reg;
    logic up_prev_reg;
    logic down_prev_reg;
    logic shclk_prev_reg;

    // previous-scan copies only move at the scan boundary
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stage_prev_reg <= 1'b0;
            up_prev_reg <= 1'b0;
            down_prev_reg <= 1'b0;
            shclk_prev_reg <= 1'b0;
        end else if (scan_pulse) begin
            stage_prev_reg <= stage_in.count;
            up_prev_reg <= udc_in.up;
            down_prev_reg <= udc_in.down;
            shclk_prev_reg <= shift_in.clock;
        end
    end

    wire stage_edge = scan_pulse & stage_in.count & ~stage_prev_reg;
    wire stage_clr = scan_pulse & stage_in.clear;
    // a count input only counts while the other one is off
    wire up_edge = scan_pulse & udc_in.up & ~up_prev_reg & ~udc_in.down;
    wire down_edge = scan_pulse & udc_in.down & ~down_prev_reg & ~udc_in.up;
    wire udc_clr = scan_pulse & udc_in.reset;
    wire shift_step = scan_pulse & shift_in.clock & ~shclk_prev_reg;
    wire shift_clr = scan_pulse & shift_in.reset;

    // ==========================================================
    // stage counter
    pcs_bcd_counter #(
        .DIGITS(4)
    ) u_stage (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .step_up(stage_edge),
        .step_down(1'b0),
        .clear(stage_clr),
        .value_reg(stage_value)
    );

    // sticky: a lowered preset or later count never drops it
    wire stage_done_next = stage_clr ? 1'b0 :
                           (stage_done_reg | (stage_value >= stage_pre_reg));

    // ==========================================================
    // up/down counter
    pcs_bcd_counter #(
        .DIGITS(8)
    ) u_updown (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .step_up(up_edge),
        .step_down(down_edge),
        .clear(udc_clr),
        .value_reg(udc_value)
    );

    wire pcs_pre_src_t pre_src = pcs_pre_src_t'(ctrl_reg[`PCS_CTRL_SRC_BIT]);
    wire [31:0] udc_preset = (pre_src == PCS_PRE_VMEM) ?
                             {udc_v_hi_reg, udc_v_lo_reg} :
                             {udc_k_hi_reg, udc_k_lo_reg};
    // bcd words compare correctly as plain binary
    wire udc_done_next = (udc_value >= udc_preset);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stage_done_reg <= 1'b0;
            udc_done_reg <= 1'b0;
        end else begin
            stage_done_reg <= stage_done_next;
            udc_done_reg <= udc_done_next;
        end
    end

    // ==========================================================
    // shift chain
    wire [IW-1:0] from_idx = shift_cfg_reg[`PCS_CFG_FROM_LSB +: IW];
    wire [IW-1:0] to_idx = shift_cfg_reg[`PCS_CFG_TO_LSB +: IW];

    pcs_relay_shift #(
        .NREL(NREL),
        .IW(IW)
    ) u_shift (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .step(shift_step),
        .data_in(shift_in.data),
        .clear(shift_clr),
        .from_idx(from_idx),
        .to_idx(to_idx),
        .relays_reg(relay_bits)
    );

    // ==========================================================
    // read decode
    logic [15:0] read_word;
    logic [15:0] relay_word_idx;

    assign relay_word_idx = bus.addr - `PCS_RELAY_BASE;

    always_comb begin
        read_word = 16'h0000;
        if (bus.addr == `PCS_ADDR_CTRL) begin
            read_word = ctrl_reg;
        end else if (bus.addr == `PCS_ADDR_STATUS) begin
            read_word[`PCS_STAT_STAGE_BIT] = stage_done_reg;
            read_word[`PCS_STAT_UDC_BIT] = udc_done_reg;
        end else if (bus.addr == `PCS_ADDR_STAGE_PRE) begin
            read_word = stage_pre_reg;
        end else if (bus.addr == `PCS_ADDR_UDC_K_LO) begin
            read_word = udc_k_lo_reg;
        end else if (bus.addr == `PCS_ADDR_UDC_K_HI) begin
            read_word = udc_k_hi_reg;
        end else if (bus.addr == `PCS_ADDR_UDC_V_LO) begin
            read_word = udc_v_lo_reg;
        end else if (bus.addr == `PCS_ADDR_UDC_V_HI) begin
            read_word = udc_v_hi_reg;
        end else if (bus.addr == `PCS_ADDR_SHIFT_CFG) begin
            read_word = shift_cfg_reg;
        end else if (bus.addr == STAGE_ADDR) begin
            read_word = stage_value;
        end else if (bus.addr == UDC_LO_ADDR) begin
            read_word = udc_value[15:0];
        end else if (bus.addr == UDC_HI_ADDR) begin
            read_word = udc_value[31:16];
        end else if (bus.addr >= `PCS_RELAY_BASE && bus.addr < RELAY_END) begin
            read_word = relay_bits[16*relay_word_idx[IW-5:0] +: 16];
        end
    end

    // data valid only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= bus.rd ? read_word : 16'h0000;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_stage_incr_digit: assert property (
        stage_edge && !stage_clr && stage_value[3:0] != 4'h9
        |=> stage_value[3:0] == $past(stage_value[3:0]) + 4'h1)
        else $error("stage counter missed an increment");
    a_stage_done_hold: assert property (
        stage_done_reg && !stage_clr |=> stage_done_reg)
        else $error("stage done bit dropped without clear");
    a_stage_value_hold: assert property (
        !stage_edge && !stage_clr |=> $stable(stage_value))
        else $error("stage value moved without an edge");
    a_stage_clear_zero: assert property (
        stage_clr |=> stage_value == 16'h0000 && !stage_done_reg)
        else $error("stage clear did not zero the counter");
    a_stage_sat_max: assert property (
        stage_value == `PCS_STAGE_MAX && !stage_clr |=> stage_value == `PCS_STAGE_MAX)
        else $error("stage counter left its maximum");
    a_edge_once_scan: assert property (
        stage_edge |=> !stage_edge)
        else $error("stage edge counted twice");
    a_udc_reset_zero: assert property (
        udc_clr |=> udc_value == 32'h00000000)
        else $error("up/down reset did not zero the value");
    a_udc_reset_wins: assert property (
        udc_clr && udc_in.up && !up_prev_reg ##1 !udc_clr |-> udc_value == 32'h00000000)
        else $error("count edge beat the reset");
    a_udc_in_range: assert property (
        udc_value <= `PCS_UDC_MAX)
        else $error("up/down value out of range");
    a_udc_both_on: assert property (
        scan_pulse && udc_in.up && udc_in.down && !udc_in.reset |=> $stable(udc_value))
        else $error("counted with both inputs on");
    a_udc_done_match: assert property (
        !sys_rst |=> udc_done_reg == ($past(udc_value) >= $past(udc_preset)))
        else $error("up/down done bit wrong");
    a_shift_entry_bit: assert property (
        shift_step && !shift_clr |=> relay_bits[$past(from_idx)] == $past(shift_in.data))
        else $error("data did not enter the start relay");
    a_shift_reset_all: assert property (
        shift_clr |=> relay_bits == '0)
        else $error("shift reset left relays set");
    a_slot_read_value: assert property (
        bus.rd && bus.addr == STAGE_ADDR |=> rdata_reg == $past(stage_value))
        else $error("current value read mismatch");

endmodule : pcs_top

// file: core/pcs_cfg.svh
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// ==========================================================
// register word addresses
`define PCS_ADDR_CTRL 16'h0010
`define PCS_ADDR_STATUS 16'h0011
`define PCS_ADDR_STAGE_PRE 16'h0012
`define PCS_ADDR_UDC_K_LO 16'h0013
`define PCS_ADDR_UDC_K_HI 16'h0014
`define PCS_ADDR_SHIFT_CFG 16'h0015
// octal 1000: current values sit at this base plus the counter number
`define PCS_CUR_BASE 16'h0200
`define PCS_RELAY_BASE 16'h0300
// octal 2000 and 2001: word-memory double word used as up/down preset
`define PCS_ADDR_UDC_V_LO 16'h0400
`define PCS_ADDR_UDC_V_HI 16'h0401

// ==========================================================
// field positions
`define PCS_CTRL_SRC_BIT 0
`define PCS_STAT_STAGE_BIT 0
`define PCS_STAT_UDC_BIT 1
`define PCS_CFG_FROM_LSB 0
`define PCS_CFG_TO_LSB 8

// ==========================================================
// reset values and limits
`define PCS_CTRL_RST 16'h0000
`define PCS_STAGE_PRE_RST 16'h0000
`define PCS_UDC_PRE_RST 16'h0000
`define PCS_SHIFT_CFG_RST 16'h0F00
`define PCS_STAGE_MAX 16'h9999
`define PCS_UDC_MAX 32'h99999999

`endif

// file: core/pcs_pkg.sv
// ==========================================================
// shared types
package pcs_pkg;

    typedef enum logic {PCS_PRE_CONST, PCS_PRE_VMEM} pcs_pre_src_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pcs_bus_req_t;

    typedef struct packed {
        logic count;
        logic clear;
    } pcs_stage_in_t;

    typedef struct packed {
        logic up;
        logic down;
        logic reset;
    } pcs_udc_in_t;

    typedef struct packed {
        logic data;
        logic clock;
        logic reset;
    } pcs_shift_in_t;

endpackage : pcs_pkg

// file: core/pcs_bcd_counter.sv
`timescale 1ns/1ps
// ==========================================================
// saturating bcd counter, clear has priority over any step
module pcs_bcd_counter #(
    parameter int DIGITS = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // control
    input wire logic step_up,
    input wire logic step_down,
    input wire logic clear,
    // value
    output logic [4*DIGITS-1:0] value_reg
);

    localparam int W = 4 * DIGITS;

    function automatic logic [W-1:0] bcd_inc(input logic [W-1:0] v);
        logic [W-1:0] r;
        logic carry;
        r = v;
        carry = 1'b1;
        for (int i = 0; i < DIGITS; i++) begin
            if (carry) begin
                if (r[4*i +: 4] == 4'h9) begin
                    r[4*i +: 4] = 4'h0;
                end else begin
                    r[4*i +: 4] = r[4*i +: 4] + 4'h1;
                    carry = 1'b0;
                end
            end
        end
        // all nines: hold the maximum rather than wrap
        return carry ? v : r;
    endfunction : bcd_inc

    function automatic logic [W-1:0] bcd_dec(input logic [W-1:0] v);
        logic [W-1:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        for (int i = 0; i < DIGITS; i++) begin
            if (borrow) begin
                if (r[4*i +: 4] == 4'h0) begin
                    r[4*i +: 4] = 4'h9;
                end else begin
                    r[4*i +: 4] = r[4*i +: 4] - 4'h1;
                    borrow = 1'b0;
                end
            end
        end
        return borrow ? v : r;
    endfunction : bcd_dec

    logic [W-1:0] value_next;

    assign value_next = clear ? '0 :
                        step_up ? bcd_inc(value_reg) :
                        step_down ? bcd_dec(value_reg) : value_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            value_reg <= '0;
        end else begin
            value_reg <= value_next;
        end
    end

endmodule : pcs_bcd_counter

// file: core/pcs_relay_shift.sv
`timescale 1ns/1ps
// ==========================================================
// relay chain shifted between a start and an end relay
module pcs_relay_shift #(
    parameter int NREL = 64,
    parameter int IW = 6
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // control
    input wire logic step,
    input wire logic data_in,
    input wire logic clear,
    input wire logic [IW-1:0] from_idx,
    input wire logic [IW-1:0] to_idx,
    // relays
    output logic [NREL-1:0] relays_reg
);

    logic fwd;
    logic [NREL-1:0] shifted;
    logic [NREL-1:0] relays_next;

    assign fwd = (from_idx <= to_idx);

    always_comb begin
        shifted = relays_reg;
        for (int i = 0; i < NREL; i++) begin
            if (fwd && i >= from_idx && i <= to_idx) begin
                if (i == from_idx) begin
                    shifted[i] = data_in;
                end else if (i > 0) begin
                    shifted[i] = relays_reg[i-1];
                end
            end else if (!fwd && i >= to_idx && i <= from_idx) begin
                if (i == from_idx) begin
                    shifted[i] = data_in;
                end else if (i < NREL - 1) begin
                    shifted[i] = relays_reg[i+1];
                end
            end
        end
    end

    // reset of the chain clears every relay, not just the block
    assign relays_next = clear ? '0 : (step ? shifted : relays_reg);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            relays_reg <= '0;
        end else begin
            relays_reg <= relays_next;
        end
    end

endmodule : pcs_relay_shift

// file: verif/pcs_ladder_model.sv
`timescale 1ns/1ps
// ==========================================================
// ladder program: presents one scan's conditions per call
module pcs_ladder_model
    import pcs_pkg::*;
(
    // clock
    input wire logic core_clk,
    // scan conditions
    output logic scan_pulse,
    output pcs_stage_in_t stage_in,
    output pcs_udc_in_t udc_in,
    output pcs_shift_in_t shift_in
);
    initial begin
        scan_pulse = 1'b0;
        stage_in = '0;
        udc_in = '0;
        shift_in = '0;
    end

    // ==========================================================
    // one scan; levels stay put afterwards like a program's image
    task automatic scan(input pcs_stage_in_t s, input pcs_udc_in_t u,
                        input pcs_shift_in_t h, input int gap);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        scan_pulse <= 1'b1;
        stage_in <= s;
        udc_in <= u;
        shift_in <= h;
        @(posedge core_clk);
        scan_pulse <= 1'b0;
        // done bits trail the value by one cycle
        @(posedge core_clk);
        #1;
    endtask : scan
endmodule : pcs_ladder_model

// file: verif/test_pcs_top.sv
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module test_pcs_top
    import pcs_pkg::*;
;
    logic core_clk;
    logic sys_rst;
    pcs_bus_req_t bus;
    logic [15:0] rdata_reg;
    logic scan_pulse;
    pcs_stage_in_t stage_in;
    pcs_udc_in_t udc_in;
    pcs_shift_in_t shift_in;
    logic stage_done_reg;
    logic udc_done_reg;
    logic [15:0] stage_value;
    logic [31:0] udc_value;
    logic [63:0] relay_bits;
    pcs_stage_in_t si;
    pcs_udc_in_t ui;
    pcs_shift_in_t hi;
    int bad_count;
    int n_tests;

    pcs_top #(.STAGE_NUM(7), .UDC_NUM(5), .NREL(64)) pcs_top_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .rdata_reg(rdata_reg),
        .scan_pulse(scan_pulse), .stage_in(stage_in), .udc_in(udc_in),
        .shift_in(shift_in), .stage_done_reg(stage_done_reg),
        .udc_done_reg(udc_done_reg), .stage_value(stage_value),
        .udc_value(udc_value), .relay_bits(relay_bits)
    );

    pcs_ladder_model pcs_ladder_model_inst (
        .core_clk(core_clk), .scan_pulse(scan_pulse), .stage_in(stage_in),
        .udc_in(udc_in), .shift_in(shift_in)
    );

    always #20 core_clk = ~core_clk;

    // ==========================================================
    // helpers
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [15:0] a, input logic [15:0] e);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1;
        chk({16'h0000, rdata_reg}, {16'h0000, e});
    endtask : rdc

    task automatic ev();
        pcs_ladder_model_inst.scan(si, ui, hi, 0);
    endtask : ev

    task automatic sedge();
        si.count = 1'b1;
        ev();
        si.count = 1'b0;
        ev();
    endtask : sedge

    // the idle count input is kept off while the other one counts
    task automatic uedge(input logic up);
        ui.up = up;
        ui.down = ~up;
        ev();
        ui.up = 1'b0;
        ui.down = 1'b0;
        ev();
    endtask : uedge

    task automatic hedge(input logic d);
        hi.data = d;
        hi.clock = 1'b1;
        ev();
        hi.clock = 1'b0;
        ev();
    endtask : hedge

    // ==========================================================
    // watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        $display("wrong value at %0t: run timed out", $time);
        conclude();
    end

    // ==========================================================
    // main sequence
    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        bus = '0;
        si = '0;
        ui = '0;
        hi = '0;
        bad_count = 0;
        n_tests = 0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;

        rdc(`PCS_ADDR_CTRL, `PCS_CTRL_RST);
        rdc(`PCS_ADDR_SHIFT_CFG, `PCS_SHIFT_CFG_RST);
        rdc(`PCS_ADDR_STAGE_PRE, `PCS_STAGE_PRE_RST);
        rdc(16'h00FF, 16'h0000);
        $display("test register defaults done");

        wr(`PCS_ADDR_STAGE_PRE, 16'h0003);
        // zero value met the zero reset preset, so the sticky bit is already on
        chk(stage_done_reg, 1'b1);
        si.clear = 1'b1;
        ev();
        si.clear = 1'b0;
        chk(stage_done_reg, 1'b0);
        sedge();
        sedge();
        chk(stage_value, 32'h2);
        chk(stage_done_reg, 1'b0);
        si.count = 1'b1;
        ev();
        ev();
        chk(stage_value, 32'h3);
        chk(stage_done_reg, 1'b1);
        si.count = 1'b0;
        ev();
        sedge();
        ev();
        chk(stage_value, 32'h4);
        chk(stage_done_reg, 1'b1);
        rdc(`PCS_CUR_BASE + 16'h0007, 16'h0004);
        si = '{count: 1'b1, clear: 1'b1};
        ev();
        chk(stage_value, 32'h0);
        chk(stage_done_reg, 1'b0);
        si = '0;
        ev();
        $display("test stage counter done");

        wr(`PCS_ADDR_UDC_K_LO, 16'h0002);
        wr(`PCS_ADDR_UDC_K_HI, 16'h0000);
        repeat (3) uedge(1'b1);
        chk(udc_value, 32'h3);
        chk(udc_done_reg, 1'b1);
        rdc(`PCS_CUR_BASE + 16'h0005, 16'h0003);
        rdc(`PCS_CUR_BASE + 16'h0006, 16'h0000);
        uedge(1'b0);
        chk(udc_done_reg, 1'b1);
        uedge(1'b0);
        chk(udc_value, 32'h1);
        chk(udc_done_reg, 1'b0);
        ui = '{up: 1'b1, down: 1'b1, reset: 1'b0};
        ev();
        chk(udc_value, 32'h1);
        ui = '0;
        ev();
        ui = '{up: 1'b1, down: 1'b0, reset: 1'b1};
        ev();
        chk(udc_value, 32'h0);
        ui.up = 1'b0;
        ev();
        ui.up = 1'b1;
        ev();
        chk(udc_value, 32'h0);
        ui = '0;
        ev();
        uedge(1'b0);
        chk(udc_value, 32'h0);
        wr(`PCS_ADDR_CTRL, 16'h0001);
        wr(`PCS_ADDR_UDC_V_LO, 16'h0001);
        wr(`PCS_ADDR_UDC_V_HI, 16'h0000);
        uedge(1'b1);
        chk(udc_done_reg, 1'b1);
        rdc(`PCS_ADDR_STATUS, 16'h0002);
        $display("test up down counter done");

        hedge(1'b1);
        chk(relay_bits[31:0], 32'h1);
        hedge(1'b0);
        chk(relay_bits[31:0], 32'h2);
        rdc(`PCS_RELAY_BASE, 16'h0002);
        // sixteen relays on a byte boundary, run from 15 down to 0
        wr(`PCS_ADDR_SHIFT_CFG, 16'h000F);
        hedge(1'b1);
        chk(relay_bits[31:0], 32'h8001);
        hi.data = 1'b0;
        hi.clock = 1'b1;
        ev();
        ev();
        chk(relay_bits[31:0], 32'h4000);
        hi = '{data: 1'b1, clock: 1'b0, reset: 1'b1};
        ev();
        hi.clock = 1'b1;
        ev();
        chk(relay_bits[31:0], 32'h0);
        $display("test shift chain done");
        conclude();
    end
endmodule : test_pcs_top
